// [common/serial_comm_pkg.sv]
// Shared constants and types for the serial communications block.
// Assumes one system clock; the serial pins are synchronised inside the block.
package serial_comm_pkg;

  // ---------------------------------------------------------------
  // Function selection and state encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_MASTER = 2'b00,
    FN_SLAVE = 2'b01,
    FN_TX = 2'b10,
    FN_RX = 2'b11
  } func_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } state_t;

  // ---------------------------------------------------------------
  // Widths, depths and counts
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [4:0] SPI_LAST_HALF_CPHA0 = 5'h10;
  localparam logic [4:0] SPI_LAST_HALF_CPHA1 = 5'h11;
  localparam logic [4:0] SPI_LAST_SCLK_HALF = 5'h0F;
  localparam logic [4:0] SPI_FIRST_SHIFT_CPHA0 = 5'h02;
  localparam logic [4:0] SPI_FIRST_SHIFT_CPHA1 = 5'h03;
  localparam logic [3:0] SLAVE_LAST_BIT = 4'h7;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [2:0] RX_CENTER = 3'h3;
  localparam logic [3:0] FRAME_DATA_END = 4'h8;
  localparam logic [3:0] FRAME_PARITY_POS = 4'h9;
  localparam logic [3:0] FRAME_STOP_POS = 4'hA;
  localparam logic [3:0] RX_STOP_NOPAR = 4'h9;
  localparam logic [3:0] RX_STOP_PAR = 4'hA;

  // ---------------------------------------------------------------
  // Line levels and values after reset
  // ---------------------------------------------------------------
  localparam logic MARK = 1'b1;
  localparam logic SPACE = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h3;

endpackage : serial_comm_pkg

// [rtl/stream_fifo.sv]
// Synchronous FIFO with valid/ready on both sides and a registered head.
// Assumes both sides run on the same clock as the storage.
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] head;
    logic head_v;
  } fifo_t;

  fifo_t q;
  fifo_t n;
  logic push;
  logic move;

  // ---------------------------------------------------------------
  // Storage and head register
  // ---------------------------------------------------------------
  // The head refills when empty or taken; a stalled reader fills the
  // store and drops in_ready.
  always_comb begin
    n = q;
    push = in_valid && (q.cnt != FULL_CNT);
    move = (!q.head_v || out_ready) && (q.cnt != '0);
    if (out_ready && q.head_v) begin
      n.head_v = 1'b0;
    end
    if (move) begin
      n.head = q.mem[q.rd];
      n.head_v = 1'b1;
      n.rd = q.rd + 1'b1;
    end
    if (push) begin
      n.mem[q.wr] = in_data;
      n.wr = q.wr + 1'b1;
    end
    n.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(move);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign in_ready = (q.cnt != FULL_CNT);
  assign out_valid = q.head_v;
  assign out_data = q.head;

endmodule : stream_fifo

// [rtl/serial_comm_block.sv]
// Serial communications block: SPI master, SPI slave, asynchronous
// transmitter and asynchronous receiver around one shift register.
// Assumes control ports come from the clk domain and serial pins
// from outside, which pass two flip-flops first.
//
// Summary of operation
// - SPI roles offer modes 0-3, MSB or LSB first.
// - Master shifts MISO in, MOSI out, via both buffers.
// - Input captured on the opposite edge, held half a bit.
// - Master bit clock is clk divided by two.
// - Master SCLK appears on aux only during a byte.
// - Master has no slave select output.
// - Each function is one 8-bit unit, never chained.
// - MISO and receive input are synchronised first.
// - Mode bit 1 picks SPI irq: buffer empty or done.
// - Status read clears transfer done; no new irq before.
// - Slave timing comes only from SCLK.
// - Slave works only while select is low.
// - Deselected slave resets, ignores inputs, drives MISO high.
// - Transmit output is a registered mux; mark when idle.
// - Transmit bit timing uses a free-running divide-by-eight.
// - Async frames are 10 bits, or 11 with parity.
// - Even or odd parity inserted on send, checked on receive.
// - Buffer write starts sending; up to 34 more bytes may queue via the FIFO.
// - Transmit irq is buffer empty or, by mode bit 1, done.
// - Receive divider held idle, released by start, samples centre.
// - Received byte goes to the buffer; input and clock echoed.
// - Receive irq is buffer full, cleared only by reading it.
// - An SPI byte is eight bits on eight clocks, full duplex.
`timescale 1ns/100ps
module serial_comm_block (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] func_sel,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb_first,
  input wire logic irq_on_complete,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic [7:0] rx_data,
  input wire logic rx_read,
  input wire logic csr_read,
  output logic rx_full,
  output logic tx_buf_empty,
  output logic xfer_done,
  output logic overrun,
  output logic parity_error,
  output logic framing_error,
  output logic busy,
  output logic irq,
  input wire logic data_in,
  input wire logic sclk_in,
  input wire logic ss_n_in,
  output logic primary_output,
  output logic aux_output
);

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] din_s;
    logic [1:0] sclk_s;
    logic [1:0] ss_n_s;
    logic sclk_prev;
    serial_comm_pkg::state_t st;
    logic [4:0] half;
    logic [3:0] bits;
    logic [2:0] div;
    logic [7:0] shift_register;
    logic rxd;
    logic pend;
    logic [7:0] transmit_buffer;
    logic txb_full;
    logic txb_par;
    logic [7:0] receive_buffer;
    logic rx_full;
    logic done;
    logic overrun;
    logic par_err;
    logic frm_err;
    logic pout;
    logic aout;
  } blk_t;

  blk_t q;
  blk_t n;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic din;
  logic sclk;
  logic ss_n;
  logic lead_edge;
  logic trail_edge;
  logic [4:0] h;
  logic sample;
  logic shift;
  logic [7:0] sh_next;
  serial_comm_pkg::func_t fn;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Bit presented on the serial output for the current shifter value.
  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction : out_bit

  // Shifter advance with the captured bit entering the empty end.
  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  function automatic logic par_of(input logic [7:0] v, input logic odd);
    par_of = (^v) ^ odd;
  endfunction : par_of

  // ---------------------------------------------------------------
  // Transmit queue ahead of the transmit buffer
  // ---------------------------------------------------------------
  stream_fifo #(
    .WIDTH(serial_comm_pkg::DATA_W),
    .DEPTH(serial_comm_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(!q.txb_full),
    .out_data(fifo_data)
  );

  // Only the second synchroniser stage is read by the logic below.
  assign din = q.din_s[1];
  assign sclk = q.sclk_s[1];
  assign ss_n = q.ss_n_s[1];
  assign fn = serial_comm_pkg::func_t'(func_sel);
  assign h = q.half + 5'h01;

  // ---------------------------------------------------------------
  // Next-state logic for all four functions
  // ---------------------------------------------------------------
  // One 8-bit shifter serves all functions;
  // no carry ports exist.
  always_comb begin
    n = q;
    sample = 1'b0;
    shift = 1'b0;
    sh_next = q.shift_register;
    lead_edge = (sclk != q.sclk_prev) && (sclk != cpol);
    trail_edge = (sclk != q.sclk_prev) && (sclk == cpol);
    n.din_s = {q.din_s[0], data_in};
    n.sclk_s = {q.sclk_s[0], sclk_in};
    n.ss_n_s = {q.ss_n_s[0], ss_n_in};
    n.sclk_prev = sclk;

    // Clears come first so that a same-cycle hardware set wins.
    if (csr_read) begin
      n.done = 1'b0;
      n.par_err = 1'b0;
      n.frm_err = 1'b0;
    end
    if (rx_read) begin
      n.rx_full = 1'b0;
      n.overrun = 1'b0;
    end

    // The queue refills an empty transmit buffer.
    if (fifo_valid && !q.txb_full) begin
      n.transmit_buffer = fifo_data;
      n.txb_full = 1'b1;
    end

    if (!enable) begin
      n.st = serial_comm_pkg::ST_IDLE;
      n.half = '0;
      n.bits = '0;
      n.div = '0;
      n.pend = 1'b0;
      n.pout = serial_comm_pkg::MARK;
      n.aout = (fn == serial_comm_pkg::FN_MASTER) ? cpol : 1'b0;
    end else begin
      unique case (fn)
        // SPI master.
        // A bit is two clocks,
        // so SCLK duty is even.
        serial_comm_pkg::FN_MASTER: begin
          if (q.st == serial_comm_pkg::ST_IDLE) begin
            if (q.txb_full) begin
              n.shift_register = q.transmit_buffer;
              n.txb_full = 1'b0;
              n.half = '0;
              n.st = serial_comm_pkg::ST_BUSY;
            end
          end else begin
            n.half = h;
            // Mode 0/2 samples on odd halves, 1/3 on even ones.
            if (cpha) begin
              sample = !h[0] && (h <= serial_comm_pkg::SPI_LAST_HALF_CPHA0);
              shift = h[0] && (h >= serial_comm_pkg::SPI_FIRST_SHIFT_CPHA1);
            end else begin
              sample = h[0] && (h <= serial_comm_pkg::SPI_LAST_SCLK_HALF);
              shift = !h[0] && (h >= serial_comm_pkg::SPI_FIRST_SHIFT_CPHA0);
            end
            if (sample) begin
              n.rxd = din;
            end
            if (shift) begin
              sh_next = shift_in(q.shift_register, q.rxd, lsb_first);
              n.shift_register = sh_next;
            end
            if (h == (cpha ? serial_comm_pkg::SPI_LAST_HALF_CPHA1
                           : serial_comm_pkg::SPI_LAST_HALF_CPHA0)) begin
              n.receive_buffer = sh_next;
              n.overrun = n.overrun | (q.rx_full & !rx_read);
              n.rx_full = 1'b1;
              n.done = 1'b1;
              n.st = serial_comm_pkg::ST_IDLE;
            end
          end
          n.pout = out_bit(n.shift_register, lsb_first);
          // Clock idles outside a byte;
          // no select output exists.
          n.aout = cpol ^ ((n.st == serial_comm_pkg::ST_BUSY) && n.half[0]
                   && (n.half <= serial_comm_pkg::SPI_LAST_SCLK_HALF));
        end

        // SPI slave.
        serial_comm_pkg::FN_SLAVE: begin
          n.aout = 1'b0;
          if (ss_n) begin
            // Deselected: inputs ignored and sequencer cleared.
            n.st = serial_comm_pkg::ST_IDLE;
            n.bits = '0;
            n.pend = 1'b0;
            n.pout = serial_comm_pkg::MARK;
          end else begin
            // Select low loads a queued byte before
            // the first edge, as modes 0/2 need.
            if ((q.st == serial_comm_pkg::ST_IDLE) && q.txb_full
                && !q.pend && (q.bits == '0)) begin
              n.shift_register = q.transmit_buffer;
              n.txb_full = 1'b0;
            end
            // All timing comes from the synchronised SCLK.
            sample = cpha ? trail_edge : lead_edge;
            shift = cpha ? q.pend : trail_edge;
            if (sample) begin
              n.rxd = din;
              n.st = serial_comm_pkg::ST_BUSY;
              n.pend = cpha;
            end
            if (shift && (q.st == serial_comm_pkg::ST_BUSY)) begin
              n.pend = 1'b0;
              sh_next = shift_in(n.shift_register, q.rxd, lsb_first);
              n.shift_register = sh_next;
              n.bits = q.bits + 4'h1;
              if (q.bits == serial_comm_pkg::SLAVE_LAST_BIT) begin
                n.receive_buffer = sh_next;
                n.overrun = n.overrun | (q.rx_full & !rx_read);
                n.rx_full = 1'b1;
                n.done = 1'b1;
                n.bits = '0;
                n.st = serial_comm_pkg::ST_IDLE;
              end
            end
            n.pout = out_bit(n.shift_register, lsb_first);
          end
        end

        // Asynchronous transmitter.
        // Divider runs free so a receiver can share the same rate.
        serial_comm_pkg::FN_TX: begin
          n.div = q.div + 3'h1;
          if (q.div == serial_comm_pkg::DIV8_LAST) begin
            if (q.st == serial_comm_pkg::ST_BUSY) begin
              n.bits = q.bits + 4'h1;
              if (q.bits < serial_comm_pkg::FRAME_DATA_END) begin
                n.pout = q.shift_register[0];
                n.shift_register = {1'b0, q.shift_register[7:1]};
              end else if ((q.bits == serial_comm_pkg::FRAME_DATA_END)
                           && parity_en) begin
                n.pout = q.txb_par;
              end else if (q.bits < serial_comm_pkg::FRAME_STOP_POS) begin
                n.pout = serial_comm_pkg::MARK;
                n.bits = serial_comm_pkg::FRAME_STOP_POS;
              end else begin
                n.done = 1'b1;
                n.st = serial_comm_pkg::ST_IDLE;
              end
            end
            // A full buffer starts the next frame at a divider wrap.
            if ((n.st == serial_comm_pkg::ST_IDLE) && q.txb_full) begin
              n.shift_register = q.transmit_buffer;
              n.txb_par = par_of(q.transmit_buffer, parity_odd);
              n.txb_full = 1'b0;
              n.bits = '0;
              n.pout = serial_comm_pkg::SPACE;
              n.st = serial_comm_pkg::ST_BUSY;
            end
          end
          if (n.st == serial_comm_pkg::ST_IDLE) begin
            n.pout = serial_comm_pkg::MARK;
          end
          // Data-bit clock rises mid-bit, giving setup and hold.
          n.aout = (n.st == serial_comm_pkg::ST_BUSY) && (n.bits != '0)
                   && (n.bits <= serial_comm_pkg::FRAME_DATA_END) && n.div[2];
        end

        // Asynchronous receiver.
        serial_comm_pkg::FN_RX: begin
          if (q.st == serial_comm_pkg::ST_IDLE) begin
            n.div = '0;
            n.bits = '0;
            if (din == serial_comm_pkg::SPACE) begin
              n.div = 3'h1;
              n.st = serial_comm_pkg::ST_BUSY;
            end
          end else begin
            n.div = q.div + 3'h1;
            if (q.div == serial_comm_pkg::RX_CENTER) begin
              n.bits = q.bits + 4'h1;
              if (q.bits == '0) begin
                if (din != serial_comm_pkg::SPACE) begin
                  n.st = serial_comm_pkg::ST_IDLE;
                end
              end else if (q.bits <= serial_comm_pkg::FRAME_DATA_END) begin
                sh_next = {din, q.shift_register[7:1]};
                n.shift_register = sh_next;
                if (q.bits == serial_comm_pkg::FRAME_DATA_END) begin
                  n.receive_buffer = sh_next;
                  n.overrun = n.overrun | (q.rx_full & !rx_read);
                  n.rx_full = 1'b1;
                end
              end else if (parity_en
                           && (q.bits == serial_comm_pkg::FRAME_PARITY_POS)) begin
                if (din != par_of(q.shift_register, parity_odd)) begin
                  n.par_err = 1'b1;
                end
              end else begin
                // Stop bit; return to idle so the next start resyncs.
                if (din != serial_comm_pkg::MARK) begin
                  n.frm_err = 1'b1;
                end
                n.st = serial_comm_pkg::ST_IDLE;
              end
            end
          end
          n.pout = din;
          n.aout = (n.st == serial_comm_pkg::ST_BUSY) && n.div[2];
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.din_s <= serial_comm_pkg::SYNC_RESET;
      q.sclk_s <= '0;
      q.ss_n_s <= serial_comm_pkg::SYNC_RESET;
      q.transmit_buffer <= serial_comm_pkg::DATA_RESET;
      q.receive_buffer <= serial_comm_pkg::DATA_RESET;
      q.pout <= serial_comm_pkg::MARK;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // SPI and transmit irq follow mode bit 1;
  // the receiver reports buffer full.
  always_comb begin
    if (fn == serial_comm_pkg::FN_RX) begin
      irq = q.rx_full;
    end else begin
      irq = irq_on_complete ? q.done : !q.txb_full;
    end
  end

  assign rx_data = q.receive_buffer;
  assign rx_full = q.rx_full;
  assign tx_buf_empty = !q.txb_full;
  assign xfer_done = q.done;
  assign overrun = q.overrun;
  assign parity_error = q.par_err;
  assign framing_error = q.frm_err;
  assign busy = (q.st == serial_comm_pkg::ST_BUSY);
  assign primary_output = q.pout;
  assign aux_output = q.aout;

endmodule : serial_comm_block

// [verification/serial_comm_block_assertions.sv]
// Port checks for the serial block, bound into its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module serial_comm_block_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] func_sel,
  input wire logic cpol,
  input wire logic irq_on_complete,
  input wire logic rx_read,
  input wire logic csr_read,
  input wire logic ss_n_in,
  input wire logic tx_buf_empty,
  input wire logic rx_full,
  input wire logic xfer_done,
  input wire logic overrun,
  input wire logic busy,
  input wire logic irq,
  input wire logic primary_output,
  input wire logic aux_output
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Reset masks all checks, so stale flag values never fire one.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_IRQ_RX: assert property (
    func_sel == serial_comm_pkg::FN_RX |-> irq == rx_full)
    else $error("rx irq wrong");
  AST_IRQ_SEL: assert property (
    func_sel != serial_comm_pkg::FN_RX |->
    irq == (irq_on_complete ? xfer_done : tx_buf_empty))
    else $error("irq source wrong");
  AST_DONE_HOLD: assert property (
    xfer_done && !csr_read |=> xfer_done) else $error("done lost");
  AST_FULL_HOLD: assert property (
    rx_full && !rx_read |=> rx_full) else $error("full lost");
  AST_OVR_FULL: assert property (
    $rose(overrun) |-> rx_full) else $error("overrun alone");
  AST_TX_MARK: assert property (
    func_sel == serial_comm_pkg::FN_TX && !primary_output &&
    $past(func_sel) == serial_comm_pkg::FN_TX |-> busy || $past(busy))
    else $error("space while idle");
  AST_MISO_IDLE: assert property (
    (func_sel == serial_comm_pkg::FN_SLAVE && ss_n_in) [*4]
    |-> primary_output) else $error("miso low unselected");
  AST_SCLK_IDLE: assert property (
    func_sel == serial_comm_pkg::FN_MASTER && !busy && !$past(busy) &&
    $past(func_sel) == serial_comm_pkg::FN_MASTER && $stable(cpol)
    |-> aux_output == cpol) else $error("sclk not gated");
  AST_SCLK_HALF: assert property (
    func_sel == serial_comm_pkg::FN_MASTER && $changed(aux_output) &&
    aux_output != cpol |=> aux_output == cpol) else $error("sclk wide");
  // Main scenarios reached.
  cover property ($rose(xfer_done));
  cover property ($rose(overrun));
  cover property (!ss_n_in && $changed(primary_output));
endmodule : serial_comm_block_assertions
bind serial_comm_block serial_comm_block_assertions chk_u (.*);

// [verification/serial_far_end.sv]
// Far-end asynchronous partner: frame sender and frame decoder.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/100ps
module serial_far_end (
  input wire logic clk,
  input wire logic on,
  input wire logic line_in,
  input wire logic parity_en,
  input wire logic parity_odd,
  output logic line_out
);
  // ---------------------------------------------------------------
  // Sender and decoder
  // ---------------------------------------------------------------
  logic [7:0] got = 8'h00;
  logic got_par = 1'b0;
  int got_cnt = 0;
  initial line_out = 1'b1;
  // Mark idle, start, data LSB first, parity, stop.
  task automatic send(input logic [7:0] b, input logic bad_par,
    input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, ^b ^ parity_odd ^ bad_par, b, 1'b0};
    if (!parity_en) f = {1'b1, ~bad_stop, b, 1'b0};
    for (int i = 0; i < (parity_en ? 11 : 10); i++) begin
      line_out = f[i];
      repeat (8) @(posedge clk);
      #1;
    end
    line_out = 1'b1; // Back to mark so a bad stop does not hold the line low once the frame ends.
  endtask : send
  // Samples each bit centre; the ninth is parity, or stop without it.
  always begin
    @(negedge line_in iff on);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (8) @(posedge clk);
      if (i < 8) got[i] = line_in;
      else got_par = line_in;
    end
    got_cnt++;
  end
endmodule : serial_far_end

// [verification/serial_comm_block_test.sv]
// Self-checking bench for the four serial functions.
// Assumes the far-end model and the bound checker are compiled first.
`timescale 1ns/100ps
module serial_comm_block_test;
  // ---------------------------------------------------------------
  // Signals, instances and shared tasks
  // ---------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, enable = 1'b0, cpol = 1'b0;
  logic cpha = 1'b0, lsb_first = 1'b0, irq_on_complete = 1'b0;
  logic parity_en = 1'b0, parity_odd = 1'b0, tx_valid = 1'b0;
  logic rx_read = 1'b0, csr_read = 1'b0, din_tb = 1'b1, fe_line;
  logic sclk_in = 1'b0, ss_n_in = 1'b1, data_in, tx_ready, rx_full;
  logic tx_buf_empty, xfer_done, overrun, busy, irq, parity_error;
  logic framing_error, primary_output, aux_output;
  logic [1:0] func_sel = 2'h0;
  logic [7:0] tx_data = 8'h00, rx_data;
  int failures = 0, comparisons = 0, cycles = 0;
  // The far end owns the data line only in receive mode.
  assign data_in = (func_sel == serial_comm_pkg::FN_RX) ? fe_line : din_tb;
  always #5 clk = ~clk;
  serial_comm_block dut_u (.clk, .rst_n, .enable, .func_sel, .cpol, .cpha,
    .lsb_first, .irq_on_complete, .parity_en, .parity_odd, .tx_valid,
    .tx_ready, .tx_data, .rx_data, .rx_read, .csr_read, .rx_full,
    .tx_buf_empty, .xfer_done, .overrun, .parity_error, .framing_error,
    .busy, .irq, .data_in, .sclk_in, .ss_n_in, .primary_output, .aux_output);
  serial_far_end fe_u (.clk, .on(func_sel == serial_comm_pkg::FN_TX),
    .line_in(primary_output), .parity_en, .parity_odd, .line_out(fe_line));
  // A hang counts as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [7:0] flags();
    return {3'h0, rx_full, irq, overrun, parity_error, framing_error};
  endfunction : flags
  // An idle cycle follows each push.
  task automatic push(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    tick(1);
  endtask : push
  task automatic clr();
    rx_read = 1'b1;
    csr_read = 1'b1;
    tick(1);
    rx_read = 1'b0;
    csr_read = 1'b0;
    tick(1);
  endtask : clr
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // MOSI is taken at the sampling SCLK edge; MISO is held steady.
  task automatic t_master(input logic [1:0] mode, input logic [7:0] b);
    logic [7:0] got;
    logic prev;
    int e;
    {cpol, cpha} = mode;
    lsb_first = mode[0];
    din_tb = mode[1];
    func_sel = serial_comm_pkg::FN_MASTER;
    got = 8'h00;
    e = 0;
    tick(4);
    prev = aux_output;
    push(b);
    for (int i = 0; i < 60 && xfer_done !== 1'b1; i++) begin
      tick(1);
      if (aux_output !== prev) begin
        e++;
        if (e[0] != cpha)
          got = lsb_first ? {primary_output, got[7:1]}
                          : {got[6:0], primary_output};
      end
      prev = aux_output;
    end
    check("mosi", b, got);
    check("sclk edges", 8'h10, e[7:0]);
    check("miso", {8{din_tb}}, rx_data);
    irq_on_complete = 1'b1;
    tick(1);
    check("irq done", 8'h01, {7'h00, irq});
    clr();
    check("irq clr", 8'h00, {7'h00, irq});
    irq_on_complete = 1'b0;
    $display("master mode %0d end", mode);
  endtask : t_master
  // Two bytes queued back to back must both come out whole.
  task automatic t_tx(input logic pe, input logic po, input logic [7:0] b);
    int c;
    func_sel = serial_comm_pkg::FN_TX;
    parity_en = pe;
    parity_odd = po;
    irq_on_complete = 1'b1;
    tick(2);
    c = fe_u.got_cnt;
    push(b);
    push(~b);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 400 && fe_u.got_cnt <= c + k; i++) tick(1);
      check("tx byte", b ^ {8{k[0]}}, fe_u.got);
      if (pe) check("par", {7'h00, ^b ^ po}, {7'h00, fe_u.got_par});
    end
    tick(16);
    check("tx irq", 8'h01, {7'h00, irq});
    clr();
    check("tx clr", 8'h01, {7'h00, primary_output & ~xfer_done});
    $display("tx end");
  endtask : t_tx
  // Flags as {full, irq, overrun, parity, framing} after each frame.
  task automatic t_rx();
    func_sel = serial_comm_pkg::FN_RX;
    parity_en = 1'b1;
    parity_odd = 1'b0;
    tick(4);
    clr();
    fe_u.send(8'h5A, 1'b0, 1'b0);
    tick(4);
    check("rx data", 8'h5A, rx_data);
    check("rx ok", 8'h18, flags());
    fe_u.send(8'hC3, 1'b1, 1'b0);
    tick(4);
    check("rx par", 8'h1E, flags());
    clr();
    fe_u.send(8'h0F, 1'b0, 1'b1);
    tick(4);
    check("rx frm", 8'h19, flags());
    clr();
    check("rx clr", 8'h00, {7'h00, irq});
    $display("rx end");
  endtask : t_rx
  // Mode 0 slave; a five-clock SCLK half covers the sync delay.
  task automatic t_slave(input logic [7:0] m, input logic [7:0] s);
    logic [7:0] got;
    func_sel = serial_comm_pkg::FN_SLAVE;
    {cpol, cpha, lsb_first} = 3'h0;
    push(s);
    tick(4);
    check("miso idle", 8'h01, {7'h00, primary_output});
    ss_n_in = 1'b0;
    tick(6);
    for (int i = 7; i >= 0; i--) begin
      din_tb = m[i];
      tick(5);
      got[i] = primary_output;
      sclk_in = 1'b1;
      tick(5);
      sclk_in = 1'b0;
    end
    tick(6);
    check("slave rx", m, rx_data);
    check("slave tx", s, got);
    ss_n_in = 1'b1;
    tick(6);
    check("miso off", 8'h01, {7'h00, primary_output});
    $display("slave end");
  endtask : t_slave
  initial begin
    tick(5);
    check("reset", 8'h17, {3'h0, primary_output, aux_output, tx_buf_empty,
      tx_ready, irq});
    rst_n = 1'b1;
    enable = 1'b1;
    tick(2);
    for (int m = 0; m < 4; m++) t_master(m[1:0], 8'hB4 ^ m[7:0]);
    t_tx(1'b0, 1'b0, 8'hA5);
    t_tx(1'b1, 1'b1, 8'h3C);
    t_tx(1'b1, 1'b0, 8'h81);
    t_rx();
    t_slave(8'h96, 8'hC3);
    print_verdict();
  end
endmodule : serial_comm_block_test
